// *** rtl/wrc_pkg.sv ***
// Shared constants and types for the wake and radio configuration bank
package wrc_pkg;

  // Host register port geometry
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;

  // Byte offsets of the retained configuration bytes
  localparam logic [10:0] OFS_WAKE_COUNT_LOW = 11'h102;
  localparam logic [10:0] OFS_WAKE_COUNT_HIGH = 11'h103;
  localparam logic [10:0] OFS_WAKE_LIMIT_LOW = 11'h104;
  localparam logic [10:0] OFS_WAKE_LIMIT_HIGH = 11'h105;
  localparam logic [10:0] OFS_LISTEN_DWELL_COUNT = 11'h106;
  localparam logic [10:0] OFS_DWELL_TICK_DIVIDER = 11'h107;
  localparam logic [10:0] OFS_LISTEN_SIGNAL_THRESHOLD = 11'h108;
  localparam logic [10:0] OFS_CHANNEL_WORD_LOW = 11'h109;
  localparam logic [10:0] OFS_CHANNEL_WORD_MID = 11'h10a;
  localparam logic [10:0] OFS_CHANNEL_WORD_HIGH = 11'h10b;
  localparam logic [10:0] OFS_BIT_RATE_LOW = 11'h10c;
  localparam logic [10:0] OFS_DEVIATION_RATE_HIGH = 11'h10d;
  localparam logic [10:0] OFS_TONE_DEVIATION_LOW = 11'h10e;
  localparam logic [10:0] OFS_DEMOD_BANDWIDTH = 11'h10f;

  // First byte held by the bank and the number of bytes it holds
  localparam logic [10:0] OFS_FIRST = OFS_WAKE_COUNT_LOW;
  localparam int REG_COUNT = 14;

  // Field positions inside the shared rate and deviation byte
  localparam int RATE_HIGH_LSB = 0;
  localparam int DEVIATION_HIGH_LSB = 4;

  // Reset values of the stored bytes
  localparam logic [7:0] RST_CFG_BYTE = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // Signal threshold offset in dBm
  localparam logic [8:0] LISTEN_THRESH_OFFSET_DBM = 9'h06b;

  // Dwell tick base: 6.5 MHz made from the 250 MHz clock by a phase step
  localparam int REF_CLK_KHZ = 250000;
  localparam int DWELL_BASE_KHZ = 6500;
  localparam int PHASE_GRAIN_KHZ = 500;
  localparam logic [9:0] PHASE_STEP = 10'(DWELL_BASE_KHZ / PHASE_GRAIN_KHZ);
  localparam logic [9:0] PHASE_MOD = 10'(REF_CLK_KHZ / PHASE_GRAIN_KHZ);
  localparam int DWELL_PRESCALE_SHIFT = 7;

  // Wake sequencer states
  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_LISTEN,
    ST_RECEIVE,
    ST_OFF
  } wrc_state_t;

endpackage

// *** rtl/wrc_sync_edge.sv ***
// Two-flop synchroniser with rising-edge pulse for a foreign-domain level
`timescale 1ns/1ps
module wrc_sync_edge import wrc_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Foreign level and its synchronised views
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);

  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
    logic rise;
  } wrc_sync_state_t;

  wrc_sync_state_t s_reg;
  wrc_sync_state_t s_next;

  // The first flop feeds only the second one; the edge uses settled flops
  always_comb begin
    s_next = s_reg;
    s_next.meta = async_in;
    s_next.stable = s_reg.meta;
    s_next.last = s_reg.stable;
    s_next.rise = s_reg.stable & ~s_reg.last;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_out = s_reg.stable;
  assign rise_out = s_reg.rise;

endmodule // wrc_sync_edge

// *** rtl/wrc_dwell_timer.sv ***
// Listen dwell timer: 6.5 MHz base, divider prescale, dwell tick count
`timescale 1ns/1ps
module wrc_dwell_timer import wrc_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [7:0] divider_in,
  input wire logic [7:0] dwell_in,
  // Status
  output logic busy_out,
  output logic done_out
);

  typedef struct packed {
    logic [9:0] phase;
    logic [14:0] pre;
    logic [7:0] ticks;
    logic busy;
    logic done;
  } wrc_timer_state_t;

  wrc_timer_state_t s_reg;
  wrc_timer_state_t s_next;
  logic [9:0] phase_sum;
  logic base_en;
  logic [14:0] pre_last;
  logic [7:0] div_eff;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    phase_sum = s_reg.phase + PHASE_STEP;
    base_en = (phase_sum >= PHASE_MOD);
    s_next.phase = base_en ? phase_sum - PHASE_MOD : phase_sum;
    // A zero divider would give no tick at all, so it acts as one
    div_eff = (divider_in == 8'h00) ? 8'h01 : divider_in;
    pre_last = {div_eff, 7'h00} - 15'h0001;
    if (start_in) begin
      s_next.phase = '0;
      s_next.pre = '0;
      s_next.ticks = '0;
      s_next.busy = (dwell_in != 8'h00);
      s_next.done = (dwell_in == 8'h00);
    end else if (abort_in) begin
      s_next.busy = 1'b0;
    end else if (s_reg.busy && base_en) begin
      if (s_reg.pre == pre_last) begin
        s_next.pre = '0;
        if (s_reg.ticks == dwell_in - 8'h01) begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.ticks = s_reg.ticks + 8'h01;
        end
      end else begin
        s_next.pre = s_reg.pre + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_out = s_reg.busy;
  assign done_out = s_reg.done;

endmodule // wrc_dwell_timer

// *** rtl/wrc_config_bank.sv ***
// Retained wake and radio configuration bank with wake sequencer
//
// Overview of operation
// - 16-bit wake counter, counts expiries, 0x102/0x103
// - Counter compared to 16-bit limit at 0x104/0x105
// - Count above limit wakes radio-off, raises interrupt
// - Interrupt only when WAKE_IRQ_EN_IN is high
// - Listen mode powers radio, receives for dwell
// - No preamble within dwell returns to sleep
// - Tick is 128 times divider at 6.5 MHz
// - Threshold dBm is register value minus 107
// - 24-bit channel word from three bytes
// - 12-bit data rate from 0x10C and nibble
// - 12-bit deviation from high nibble and 0x10E
// - Byte at 0x10F sets demodulator bandwidth
`timescale 1ns/1ps
module wrc_config_bank import wrc_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  // Host register port
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [DATA_W-1:0] REG_WDATA_IN,
  output logic [DATA_W-1:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // Wake timer, listen control and radio status
  input wire logic WAKE_EXPIRE_IN,
  input wire logic LISTEN_MODE_EN_IN,
  input wire logic WAKE_IRQ_EN_IN,
  input wire logic PREAMBLE_DET_IN,
  input wire logic SLEEP_REQ_IN,
  input wire logic IRQ_ACK_IN,
  // Power state outputs
  output logic SLEEP_OUT,
  output logic RADIO_POWER_OUT,
  output logic RX_ENABLE_OUT,
  output logic RADIO_OFF_STATE_OUT,
  output logic WAKE_IRQ_OUT,
  // Radio parameter outputs
  output logic [23:0] CHANNEL_WORD_OUT,
  output logic [11:0] DATA_RATE_OUT,
  output logic [11:0] TONE_DEVIATION_OUT,
  output logic [7:0] DEMOD_BANDWIDTH_OUT,
  output logic signed [8:0] LISTEN_THRESH_DBM_OUT
);

  // Byte indices inside the stored array
  localparam logic [3:0] IDX_COUNT_LOW = 4'(OFS_WAKE_COUNT_LOW - OFS_FIRST);
  localparam logic [3:0] IDX_COUNT_HIGH = 4'(OFS_WAKE_COUNT_HIGH - OFS_FIRST);
  localparam logic [3:0] IDX_LIMIT_LOW = 4'(OFS_WAKE_LIMIT_LOW - OFS_FIRST);
  localparam logic [3:0] IDX_LIMIT_HIGH = 4'(OFS_WAKE_LIMIT_HIGH - OFS_FIRST);
  localparam logic [3:0] IDX_DWELL =
    4'(OFS_LISTEN_DWELL_COUNT - OFS_FIRST);
  localparam logic [3:0] IDX_DIVIDER =
    4'(OFS_DWELL_TICK_DIVIDER - OFS_FIRST);
  localparam logic [3:0] IDX_THRESH =
    4'(OFS_LISTEN_SIGNAL_THRESHOLD - OFS_FIRST);
  localparam logic [3:0] IDX_CHAN_LOW = 4'(OFS_CHANNEL_WORD_LOW - OFS_FIRST);
  localparam logic [3:0] IDX_CHAN_MID = 4'(OFS_CHANNEL_WORD_MID - OFS_FIRST);
  localparam logic [3:0] IDX_CHAN_HIGH =
    4'(OFS_CHANNEL_WORD_HIGH - OFS_FIRST);
  localparam logic [3:0] IDX_RATE_LOW = 4'(OFS_BIT_RATE_LOW - OFS_FIRST);
  localparam logic [3:0] IDX_SHARED =
    4'(OFS_DEVIATION_RATE_HIGH - OFS_FIRST);
  localparam logic [3:0] IDX_DEV_LOW = 4'(OFS_TONE_DEVIATION_LOW - OFS_FIRST);
  localparam logic [3:0] IDX_BANDWIDTH = 4'(OFS_DEMOD_BANDWIDTH - OFS_FIRST);

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] cfg;
    wrc_state_t state;
    logic [7:0] rdata;
    logic rvalid;
    logic sleep;
    logic radio_power;
    logic rx_enable;
    logic radio_off;
    logic irq;
    logic [23:0] channel_word;
    logic [11:0] data_rate;
    logic [11:0] tone_deviation;
    logic [7:0] demod_bandwidth;
    logic [8:0] listen_thresh;
  } wrc_bank_state_t;

  wrc_bank_state_t s_reg;
  wrc_bank_state_t s_next;

  // Expiry edge from the slow wake-up timer domain
  logic expire_pulse;

  // Dwell timer handshake
  logic timer_start;
  logic timer_abort;
  logic timer_busy;
  logic timer_done;

  // Working values of the sequencer
  logic wr_hit;
  logic rd_hit;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [15:0] count_now;
  logic [15:0] count_inc;
  logic [15:0] limit_now;
  logic limit_passed;

  // Address decode shared by reads and writes
  function automatic logic bank_hit(input logic [ADDR_W-1:0] addr);
    bank_hit = (addr >= OFS_FIRST) &&
      (addr < OFS_FIRST + 11'(REG_COUNT));
  endfunction

  function automatic logic [3:0] bank_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFS_FIRST;
    bank_index = rel[3:0];
  endfunction

  wrc_sync_edge u_expire_sync (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .async_in(WAKE_EXPIRE_IN),
    .level_out(),
    .rise_out(expire_pulse)
  );

  wrc_dwell_timer u_dwell_timer (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .start_in(timer_start),
    .abort_in(timer_abort),
    .divider_in(s_reg.cfg[IDX_DIVIDER]),
    .dwell_in(s_reg.cfg[IDX_DWELL]),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    timer_start = 1'b0;
    timer_abort = 1'b0;

    wr_hit = REG_WR_IN && bank_hit(REG_ADDR_IN);
    rd_hit = bank_hit(REG_ADDR_IN);
    wr_idx = bank_index(REG_ADDR_IN);
    rd_idx = bank_index(REG_ADDR_IN);

    // Host writes land first; every byte but the wake count holds until rewritten
    if (wr_hit) begin
      s_next.cfg[wr_idx] = REG_WDATA_IN;
    end

    // Reads return the stored byte, zero outside the bank
    if (REG_RD_IN) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_hit ? s_reg.cfg[rd_idx] : RST_READ_DATA;
    end

    // An expiry in a write cycle adds onto the written value, never lost
    count_now = {s_next.cfg[IDX_COUNT_HIGH], s_next.cfg[IDX_COUNT_LOW]};
    count_inc = count_now + 16'h0001;
    limit_now = {s_next.cfg[IDX_LIMIT_HIGH], s_next.cfg[IDX_LIMIT_LOW]};
    limit_passed = (count_inc > limit_now);
    if (expire_pulse) begin
      s_next.cfg[IDX_COUNT_HIGH] = count_inc[15:8];
      s_next.cfg[IDX_COUNT_LOW] = count_inc[7:0];
    end

    unique case (s_reg.state)
      ST_SLEEP: begin
        if (expire_pulse) begin
          if (limit_passed) begin
            s_next.state = ST_OFF;
          end else if (LISTEN_MODE_EN_IN) begin
            s_next.state = ST_LISTEN;
            timer_start = 1'b1;
          end
        end
      end
      ST_LISTEN: begin
        if (PREAMBLE_DET_IN) begin
          s_next.state = ST_RECEIVE;
          timer_abort = 1'b1;
        end else if (timer_done) begin
          s_next.state = ST_SLEEP;
        end
      end
      ST_RECEIVE: begin
        if (SLEEP_REQ_IN) begin
          s_next.state = ST_SLEEP;
        end
      end
      ST_OFF: begin
        if (SLEEP_REQ_IN) begin
          s_next.state = ST_SLEEP;
        end
      end
    endcase

    // Sticky interrupt: a new set beats an acknowledge in the same cycle
    if (s_reg.state == ST_SLEEP && expire_pulse && limit_passed &&
        WAKE_IRQ_EN_IN) begin
      s_next.irq = 1'b1;
    end else if (IRQ_ACK_IN) begin
      s_next.irq = 1'b0;
    end

    // Power outputs follow the next state so they move with it
    s_next.sleep = (s_next.state == ST_SLEEP);
    s_next.radio_power = (s_next.state == ST_LISTEN) ||
      (s_next.state == ST_RECEIVE);
    s_next.rx_enable = (s_next.state == ST_LISTEN) ||
      (s_next.state == ST_RECEIVE);
    s_next.radio_off = (s_next.state == ST_OFF);

    // Radio parameters are registered from the stored bytes; the threshold is its byte minus 107
    s_next.channel_word = {s_next.cfg[IDX_CHAN_HIGH],
      s_next.cfg[IDX_CHAN_MID], s_next.cfg[IDX_CHAN_LOW]};
    s_next.data_rate = {s_next.cfg[IDX_SHARED][RATE_HIGH_LSB +: 4],
      s_next.cfg[IDX_RATE_LOW]};
    s_next.tone_deviation = {
      s_next.cfg[IDX_SHARED][DEVIATION_HIGH_LSB +: 4],
      s_next.cfg[IDX_DEV_LOW]};
    s_next.demod_bandwidth = s_next.cfg[IDX_BANDWIDTH];
    s_next.listen_thresh = {1'b0, s_next.cfg[IDX_THRESH]} -
      LISTEN_THRESH_OFFSET_DBM;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      s_reg.cfg <= {REG_COUNT{RST_CFG_BYTE}};
      s_reg.state <= ST_SLEEP;
      s_reg.rdata <= RST_READ_DATA;
      s_reg.rvalid <= 1'b0;
      s_reg.sleep <= 1'b1;
      s_reg.radio_power <= 1'b0;
      s_reg.rx_enable <= 1'b0;
      s_reg.radio_off <= 1'b0;
      s_reg.irq <= 1'b0;
      s_reg.channel_word <= '0;
      s_reg.data_rate <= '0;
      s_reg.tone_deviation <= '0;
      s_reg.demod_bandwidth <= '0;
      s_reg.listen_thresh <= 9'h000 - LISTEN_THRESH_OFFSET_DBM;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output is a flop of the state struct
  assign REG_RDATA_OUT = s_reg.rdata;
  assign REG_RVALID_OUT = s_reg.rvalid;
  assign SLEEP_OUT = s_reg.sleep;
  assign RADIO_POWER_OUT = s_reg.radio_power;
  assign RX_ENABLE_OUT = s_reg.rx_enable;
  assign RADIO_OFF_STATE_OUT = s_reg.radio_off;
  assign WAKE_IRQ_OUT = s_reg.irq;
  assign CHANNEL_WORD_OUT = s_reg.channel_word;
  assign DATA_RATE_OUT = s_reg.data_rate;
  assign TONE_DEVIATION_OUT = s_reg.tone_deviation;
  assign DEMOD_BANDWIDTH_OUT = s_reg.demod_bandwidth;
  assign LISTEN_THRESH_DBM_OUT = s_reg.listen_thresh;

endmodule // wrc_config_bank

// *** verification/wrc_config_bank_chk.sv ***
// Port checker for the wake and radio configuration bank
`timescale 1ns/1ps
module wrc_config_bank_chk import wrc_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  // Host register port
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_RVALID_OUT,
  // Wake and power state
  input wire logic LISTEN_MODE_EN_IN,
  input wire logic WAKE_IRQ_EN_IN,
  input wire logic SLEEP_OUT,
  input wire logic RADIO_POWER_OUT,
  input wire logic RX_ENABLE_OUT,
  input wire logic RADIO_OFF_STATE_OUT,
  input wire logic WAKE_IRQ_OUT,
  // Radio parameters
  input wire logic [23:0] CHANNEL_WORD_OUT,
  input wire logic [11:0] DATA_RATE_OUT,
  input wire logic [11:0] TONE_DEVIATION_OUT,
  input wire logic [7:0] DEMOD_BANDWIDTH_OUT,
  input wire logic signed [8:0] LISTEN_THRESH_DBM_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  AST_READ_ANSWER: assert property (1'h1 |=>
    REG_RVALID_OUT == $past(REG_RD_IN)) else $error("read answer slip");
  AST_CHAN_MID: assert property (
    REG_WR_IN && REG_ADDR_IN == OFS_CHANNEL_WORD_MID |=>
    CHANNEL_WORD_OUT[15:8] == $past(REG_WDATA_IN))
    else $error("channel mid byte");
  AST_SHARED_NIBBLES: assert property (
    REG_WR_IN && REG_ADDR_IN == OFS_DEVIATION_RATE_HIGH |=>
    {TONE_DEVIATION_OUT[11:8], DATA_RATE_OUT[11:8]} == $past(REG_WDATA_IN))
    else $error("shared nibble byte");
  AST_RATE_LOW: assert property (
    REG_WR_IN && REG_ADDR_IN == OFS_BIT_RATE_LOW |=>
    DATA_RATE_OUT[7:0] == $past(REG_WDATA_IN)) else $error("rate low");
  AST_DEV_LOW: assert property (
    REG_WR_IN && REG_ADDR_IN == OFS_TONE_DEVIATION_LOW |=>
    TONE_DEVIATION_OUT[7:0] == $past(REG_WDATA_IN)) else $error("dev low");
  AST_BANDWIDTH: assert property (
    REG_WR_IN && REG_ADDR_IN == OFS_DEMOD_BANDWIDTH |=>
    DEMOD_BANDWIDTH_OUT == $past(REG_WDATA_IN)) else $error("bandwidth");
  AST_THRESH: assert property (
    REG_WR_IN && REG_ADDR_IN == OFS_LISTEN_SIGNAL_THRESHOLD |=>
    LISTEN_THRESH_DBM_OUT ==
    9'({1'h0, $past(REG_WDATA_IN)} - LISTEN_THRESH_OFFSET_DBM))
    else $error("threshold dBm");
  AST_IRQ_CAUSE: assert property ($rose(WAKE_IRQ_OUT) |->
    $past(WAKE_IRQ_EN_IN) && RADIO_OFF_STATE_OUT) else $error("irq cause");
  AST_LISTEN_ENTRY: assert property ($rose(RADIO_POWER_OUT) |->
    $past(SLEEP_OUT) && $past(LISTEN_MODE_EN_IN) && RX_ENABLE_OUT &&
    !SLEEP_OUT) else $error("listen entry");
  AST_OFF_STATE: assert property (RADIO_OFF_STATE_OUT |->
    !SLEEP_OUT && !RADIO_POWER_OUT) else $error("off state overlap");
endmodule // wrc_config_bank_chk

bind wrc_config_bank wrc_config_bank_chk u_chk (
  .REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_RVALID_OUT(REG_RVALID_OUT),
  .LISTEN_MODE_EN_IN(LISTEN_MODE_EN_IN), .WAKE_IRQ_EN_IN(WAKE_IRQ_EN_IN),
  .SLEEP_OUT(SLEEP_OUT), .RADIO_POWER_OUT(RADIO_POWER_OUT),
  .RX_ENABLE_OUT(RX_ENABLE_OUT), .RADIO_OFF_STATE_OUT(RADIO_OFF_STATE_OUT),
  .WAKE_IRQ_OUT(WAKE_IRQ_OUT), .CHANNEL_WORD_OUT(CHANNEL_WORD_OUT),
  .DATA_RATE_OUT(DATA_RATE_OUT), .TONE_DEVIATION_OUT(TONE_DEVIATION_OUT),
  .DEMOD_BANDWIDTH_OUT(DEMOD_BANDWIDTH_OUT),
  .LISTEN_THRESH_DBM_OUT(LISTEN_THRESH_DBM_OUT)
);

// *** verification/wrc_config_bank_tb.sv ***
// Self-checking bench for the wake and radio configuration bank
`timescale 1ns/1ps
module wrc_config_bank_tb import wrc_pkg::*; ();
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic rvalid, sleep, power, rx_en, off_st, irq;
  logic expire = 1'h0;
  logic listen = 1'h0;
  logic irq_en = 1'h1;
  logic preamble = 1'h0;
  logic sleep_req = 1'h0;
  logic ack = 1'h0;
  logic [23:0] chan;
  logic [11:0] rate, dev;
  logic [7:0] bw;
  logic signed [8:0] thresh;
  logic [7:0] b [REG_COUNT];
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int on_cnt = 0;
  // Ideal dwell of one tick at divider 1; latency and phase-step jitter
  // are absorbed by a small tolerance
  int dwell_clks = 128 * REF_CLK_KHZ / DWELL_BASE_KHZ;

  wrc_config_bank uut (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .WAKE_EXPIRE_IN(expire), .LISTEN_MODE_EN_IN(listen),
    .WAKE_IRQ_EN_IN(irq_en), .PREAMBLE_DET_IN(preamble),
    .SLEEP_REQ_IN(sleep_req), .IRQ_ACK_IN(ack), .SLEEP_OUT(sleep),
    .RADIO_POWER_OUT(power), .RX_ENABLE_OUT(rx_en),
    .RADIO_OFF_STATE_OUT(off_st), .WAKE_IRQ_OUT(irq),
    .CHANNEL_WORD_OUT(chan), .DATA_RATE_OUT(rate),
    .TONE_DEVIATION_OUT(dev), .DEMOD_BANDWIDTH_OUT(bw),
    .LISTEN_THRESH_DBM_OUT(thresh)
  );

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (power === 1'h1)
      on_cnt <= on_cnt + 1;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // Read strobe lasts one cycle; data is taken with the valid pulse
  task automatic rd_reg(input logic [10:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk(rvalid, 1'h1);
    chk(rdata, exp);
  endtask

  task automatic set_wake(input logic [15:0] c, input logic [15:0] l);
    wr_reg(OFS_WAKE_COUNT_LOW, c[7:0]);
    wr_reg(OFS_WAKE_COUNT_HIGH, c[15:8]);
    wr_reg(OFS_WAKE_LIMIT_LOW, l[7:0]);
    wr_reg(OFS_WAKE_LIMIT_HIGH, l[15:8]);
  endtask

  // Expiry levels are held for several clocks for the synchroniser
  task automatic expire_n(input int n);
    repeat (n) begin
      @(posedge clk);
      expire <= 1'h1;
      repeat (3) @(posedge clk);
      expire <= 1'h0;
      repeat (4) @(posedge clk);
    end
    @(negedge clk);
  endtask

  task automatic pulse(input logic a, input logic s);
    @(posedge clk);
    ack <= a;
    sleep_req <= s;
    @(posedge clk);
    ack <= 1'h0;
    sleep_req <= 1'h0;
    @(negedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk({15'h0000, thresh}, 9'(9'h000 - LISTEN_THRESH_OFFSET_DBM));
    for (int i = 0; i < REG_COUNT; i++) begin
      rd_reg(OFS_FIRST + 11'(i), 8'h00);
      b[i] = 8'(8'h3c + 8'h17 * i);
      wr_reg(OFS_FIRST + 11'(i), b[i]);
    end
    for (int i = 0; i < REG_COUNT; i++)
      rd_reg(OFS_FIRST + 11'(i), b[i]);
    chk(chan, {b[9], b[8], b[7]});
    chk(rate, {b[11][3:0], b[10]});
    chk(dev, {b[11][7:4], b[12]});
    chk(bw, b[13]);
    chk({15'h0000, thresh}, 9'({1'h0, b[6]} - 9'h06b));
    wr_reg(11'h110, 8'haa);
    rd_reg(11'h110, 8'h00);
    rd_reg(11'h101, 8'h00);
    set_wake(16'h0000, 16'h0002);
    expire_n(2);
    chk(off_st, 1'h0);
    rd_reg(OFS_WAKE_COUNT_LOW, 8'h02);
    expire_n(1);
    chk({off_st, irq, sleep}, 3'h6);
    pulse(1'h1, 1'h1);
    chk({irq, sleep}, 2'h1);
    @(posedge clk);
    irq_en <= 1'h0;
    set_wake(16'h00ff, 16'h0100);
    expire_n(1);
    chk(off_st, 1'h0);
    rd_reg(OFS_WAKE_COUNT_LOW, 8'h00);
    rd_reg(OFS_WAKE_COUNT_HIGH, 8'h01);
    expire_n(1);
    chk({off_st, irq}, 2'h2);
    pulse(1'h0, 1'h1);
    set_wake(16'h0000, 16'hffff);
    wr_reg(OFS_LISTEN_DWELL_COUNT, 8'h00);
    wr_reg(OFS_DWELL_TICK_DIVIDER, 8'h01);
    @(posedge clk);
    listen <= 1'h1;
    @(negedge clk);
    on_cnt = 0;
    expire_n(1);
    repeat (4) @(negedge clk);
    chk(on_cnt > 0 && on_cnt < 5, 1'h1);
    chk(sleep, 1'h1);
    wr_reg(OFS_LISTEN_DWELL_COUNT, 8'h01);
    @(negedge clk);
    on_cnt = 0;
    expire_n(1);
    repeat (5200) @(negedge clk);
    chk(on_cnt > dwell_clks - 20 && on_cnt < dwell_clks + 20, 1'h1);
    chk(sleep, 1'h1);
    expire_n(1);
    @(posedge clk);
    preamble <= 1'h1;
    @(posedge clk);
    preamble <= 1'h0;
    repeat (5200) @(negedge clk);
    chk({power, rx_en, sleep}, 3'h6);
    pulse(1'h0, 1'h1);
    chk(sleep, 1'h1);
    report_and_stop();
  end
endmodule // wrc_config_bank_tb
